//--- rtl/kpl_regs.vh
// register map, field positions and timing constants of the keypad parameter lock
`ifndef KPL_REGS_VH
`define KPL_REGS_VH
`define KPL_CTRL_OFF      12'h000
`define KPL_STAT_OFF      12'h004
`define KPL_ENC_OFF       12'h008
`define KPL_CTRL_RELOCK   0
`define KPL_CTRL_KEYEN    1
`define KPL_CTRL_RST      2'h2
`define KPL_STAT_LOCKEN   0
`define KPL_STAT_UNLOCKED 1
`define KPL_STAT_ENTRY    2
`define KPL_PW_ZERO       16'h0000
`define KPL_ENC_KEY       16'h3552
`define KPL_UNLOCK_S      64'd300
`define KPL_CLK_HZ        64'd200000000
`define KPL_UNLOCK_CYC    (`KPL_UNLOCK_S * `KPL_CLK_HZ)
`define KPL_DISP_VALUE    2'h0
`define KPL_DISP_PASS     2'h1
`define KPL_DISP_ERR      2'h2
`define KPL_DISP_BLANK    2'h3
`endif

//--- rtl/kpl_window_timer.v
// retriggerable unlock window timer
`timescale 1ns/100ps
`include "kpl_regs.vh"
module kpl_window_timer #(
   parameter        CW  = 36,
   parameter [63:0] CYC = `KPL_UNLOCK_CYC
) (
   input  wire core_clk_in,
   input  wire resetn_in,
   input  wire start_in,
   input  wire stop_in,
   output wire expire_out
);
   localparam [CW-1:0] LAST = CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
   reg [CW-1:0] cnt_q;
   reg          run_q;
   reg          exp_q;
   assign expire_out = exp_q;
   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= {CW{1'b0}};
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         exp_q <= 1'b0;
         if (stop_in) begin
            run_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
         end else if (start_in) begin
            // any key restarts from zero
            run_q <= 1'b1;
            cnt_q <= {CW{1'b0}};
         end else if (run_q) begin
            if (cnt_q == LAST) begin
               run_q <= 1'b0;
               exp_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // kpl_window_timer

//--- rtl/kpl_lock.v
// keypad parameter lock and user password logic with apb status access
`timescale 1ns/100ps
`include "kpl_regs.vh"
module kpl_lock #(
   parameter        CW         = 36,
   parameter [63:0] UNLOCK_CYC = `KPL_UNLOCK_CYC
) (
   input  wire        core_clk_in,
   input  wire        resetn_in,
   input  wire        key_up_in,
   input  wire        key_down_in,
   input  wire        key_enter_in,
   input  wire        key_other_in,
   input  wire        pw_sel_in,
   input  wire        edit_enter_in,
   input  wire        factory_restore_in,
   input  wire [15:0] nv_password_in,
   input  wire        nv_lock_en_in,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output wire [15:0] disp_value_out,
   output wire [1:0]  disp_mode_out,
   output wire        edit_grant_out,
   output wire        nv_write_out,
   output wire [15:0] nv_password_out,
   output wire        nv_lock_en_out
);
   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_SHOW  = 3'b010;
   localparam [2:0] ST_ENTRY = 3'b100;

   // step a four digit bcd value up or down by one, wrapping
   function [15:0] bcd_step;
      input [15:0] v;
      input        dn;
      integer      i;
      reg          c;
      reg   [3:0]  d;
      begin
         c = 1'b1;
         bcd_step = v;
         for (i = 0; i < 4; i = i + 1) begin
            d = v[4*i +: 4];
            if (c) begin
               if (dn) begin
                  c = (d == 4'h0);
                  d = c ? 4'h9 : d - 4'h1;
               end else begin
                  c = (d == 4'h9);
                  d = c ? 4'h0 : d + 4'h1;
               end
            end
            bcd_step[4*i +: 4] = d;
         end
      end
   endfunction

   // digitwise add of a fixed key, mod ten; hides the value, zero maps to the key
   function [15:0] pw_encode;
      input [15:0] v;
      integer      i;
      reg   [4:0]  s;
      reg   [15:0] k;
      begin
         k = `KPL_ENC_KEY;
         pw_encode = 16'h0000;
         for (i = 0; i < 4; i = i + 1) begin
            s = {1'b0, v[4*i +: 4]} + {1'b0, k[4*i +: 4]};
            if (s > 5'd9)
               s = s - 5'd10;
            pw_encode[4*i +: 4] = s[3:0];
         end
      end
   endfunction

   // pin synchronisers: keys are asynchronous to the core clock
   wire [3:0] key_raw = {key_other_in, key_enter_in, key_down_in, key_up_in};
   reg  [3:0] key_m_q;
   reg  [3:0] key_s_q;
   reg  [3:0] key_p_q;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_sync
         always @(posedge core_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               key_m_q[g] <= 1'b0;
               key_s_q[g] <= 1'b0;
               key_p_q[g] <= 1'b0;
            end else begin
               key_m_q[g] <= key_raw[g];
               key_s_q[g] <= key_m_q[g];
               key_p_q[g] <= key_s_q[g];
            end
         end
      end
   endgenerate

   reg  [1:0]  ctrl_q;
   wire        keys_on  = ctrl_q[`KPL_CTRL_KEYEN];
   wire [3:0]  key_rise = key_s_q & ~key_p_q & {4{keys_on}};
   wire        k_up     = key_rise[0];
   wire        k_down   = key_rise[1];
   wire        k_enter  = key_rise[2];
   wire        k_any    = |key_rise;

   reg  [2:0]  st_q;
   reg  [15:0] entry_q;
   reg  [15:0] pw_q;
   reg         lock_en_q;
   reg         unlocked_q;
   reg         load_q;
   reg         sel_p_q;
   reg  [15:0] disp_q;
   reg  [1:0]  mode_q;
   reg         grant_q;
   reg         nv_we_q;
   reg         relock_q;
   wire        expire;

   wire locked   = lock_en_q & ~unlocked_q;
   wire pw_match = (entry_q == pw_q);
   wire pw_open  = pw_sel_in & ~sel_p_q;

   // unlock window restarts on any key press while unlocked
   kpl_window_timer #(
      .CW  (CW),
      .CYC (UNLOCK_CYC)
   ) u_timer (
      .core_clk_in (core_clk_in),
      .resetn_in   (resetn_in),
      .start_in    (k_any & unlocked_q | (st_q == ST_ENTRY) & k_enter & locked & pw_match),
      .stop_in     (~lock_en_q | relock_q),
      .expire_out  (expire)
   );

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q       <= ST_IDLE;
         entry_q    <= `KPL_PW_ZERO;
         pw_q       <= `KPL_PW_ZERO;
         lock_en_q  <= 1'b0;
         unlocked_q <= 1'b0;
         load_q     <= 1'b1;
         sel_p_q    <= 1'b0;
         disp_q     <= `KPL_PW_ZERO;
         mode_q     <= `KPL_DISP_BLANK;
         grant_q    <= 1'b0;
         nv_we_q    <= 1'b0;
      end else begin
         grant_q <= 1'b0;
         nv_we_q <= 1'b0;
         sel_p_q <= pw_sel_in;
         load_q  <= 1'b0;
         if (load_q) begin
            // stored values come back from nonvolatile storage after reset
            pw_q      <= nv_password_in;
            lock_en_q <= nv_lock_en_in & (nv_password_in != `KPL_PW_ZERO);
         end else if (expire | relock_q) begin
            unlocked_q <= 1'b0;
         end
         // factory_restore_in is deliberately not used on the password state
         if (edit_enter_in & ~pw_sel_in) begin
            if (locked) begin
               mode_q <= `KPL_DISP_ERR;
            end else begin
               grant_q <= 1'b1;
            end
         end
         if (!pw_sel_in) begin
            st_q <= ST_IDLE;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  if (pw_open) begin
                     st_q   <= ST_SHOW;
                     disp_q <= pw_encode(pw_q);
                     mode_q <= `KPL_DISP_VALUE;
                  end
               end
               ST_SHOW: begin
                  if (k_up | k_down) begin
                     st_q    <= ST_ENTRY;
                     entry_q <= `KPL_PW_ZERO;
                     disp_q  <= `KPL_PW_ZERO;
                     mode_q  <= `KPL_DISP_VALUE;
                  end
               end
               ST_ENTRY: begin
                  if (k_up | k_down) begin
                     entry_q <= bcd_step(entry_q, k_down);
                     disp_q  <= bcd_step(entry_q, k_down);
                     mode_q  <= `KPL_DISP_VALUE;
                  end else if (k_enter) begin
                     st_q <= ST_SHOW;
                     if (locked) begin
                        if (pw_match) begin
                           unlocked_q <= 1'b1;
                           mode_q     <= `KPL_DISP_PASS;
                        end else begin
                           mode_q <= `KPL_DISP_ERR;
                        end
                     end else if (entry_q == `KPL_PW_ZERO) begin
                        lock_en_q  <= 1'b0;
                        unlocked_q <= 1'b0;
                        pw_q       <= `KPL_PW_ZERO;
                        nv_we_q    <= 1'b1;
                        mode_q     <= `KPL_DISP_PASS;
                     end else begin
                        // a fresh password from the lock-off state locks at once; from the unlocked state unlocked_q is kept
                        pw_q       <= entry_q;
                        lock_en_q  <= 1'b1;
                        unlocked_q <= lock_en_q & unlocked_q;
                        nv_we_q    <= 1'b1;
                        mode_q     <= `KPL_DISP_PASS;
                     end
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // apb slave, one wait state: pready rises in the second access cycle
   reg         pready_q;
   reg         pslverr_q;
   reg  [31:0] prdata_q;
   wire        acc    = psel & penable & ~pready_q;
   wire        hit_c  = (paddr == `KPL_CTRL_OFF);
   wire        hit_s  = (paddr == `KPL_STAT_OFF);
   wire        hit_e  = (paddr == `KPL_ENC_OFF);

   always @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         ctrl_q    <= `KPL_CTRL_RST;
         relock_q  <= 1'b0;
      end else begin
         pready_q  <= acc;
         pslverr_q <= 1'b0;
         relock_q  <= 1'b0;
         if (acc) begin
            prdata_q <= 32'h0000_0000;
            if (hit_c) begin
               if (pwrite) begin
                  ctrl_q   <= {pwdata[`KPL_CTRL_KEYEN], 1'b0};
                  // software relock ends the window early; stored password unchanged
                  relock_q <= pwdata[`KPL_CTRL_RELOCK];
               end else begin
                  prdata_q <= {30'h0, ctrl_q};
               end
            end else if (hit_s) begin
               if (!pwrite)
                  prdata_q <= {29'h0, st_q == ST_ENTRY, unlocked_q, lock_en_q};
            end else if (hit_e) begin
               // only the encoded form is readable over the bus; nv_password_out carries the plain value
               if (!pwrite)
                  prdata_q <= {16'h0, pw_encode(pw_q)};
            end else begin
               pslverr_q <= 1'b1;
            end
         end
      end
   end

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign disp_value_out  = disp_q;
   assign disp_mode_out   = mode_q;
   assign edit_grant_out  = grant_q;
   assign nv_write_out    = nv_we_q;
   assign nv_password_out = pw_q;
   assign nv_lock_en_out  = lock_en_q;
endmodule // kpl_lock

//--- dv/kpl_lock_sva.sv
// port assertions for the keypad parameter lock
`timescale 1ns/100ps
`include "kpl_regs.vh"
module kpl_lock_sva (
   input wire        core_clk_in,
   input wire        resetn_in,
   input wire        pw_sel_in,
   input wire        edit_enter_in,
   input wire        factory_restore_in,
   input wire [1:0]  disp_mode_out,
   input wire [15:0] disp_value_out,
   input wire        edit_grant_out,
   input wire        nv_write_out,
   input wire [15:0] nv_password_out,
   input wire        nv_lock_en_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   grant_when_open_a:
      assert property (edit_enter_in && !pw_sel_in && !nv_lock_en_out |=> edit_grant_out)
      else $error("edit refused with lock off");
   grant_has_cause_a:
      assert property (edit_grant_out |-> $past(edit_enter_in) && !$past(pw_sel_in))
      else $error("edit granted without request");
   nonzero_locks_a:
      assert property (nv_write_out && nv_password_out != `KPL_PW_ZERO |-> nv_lock_en_out)
      else $error("nonzero password stored without lock");
   zero_unlocks_a:
      assert property (nv_write_out && nv_password_out == `KPL_PW_ZERO |-> !nv_lock_en_out)
      else $error("zero password stored with lock on");
   restore_keeps_a:
      assert property (factory_restore_in && !pw_sel_in
         |=> $stable(nv_password_out) && $stable(nv_lock_en_out))
      else $error("restore touched password");
   open_shows_value_a:
      assert property ($rose(pw_sel_in) |-> ##[1:3] disp_mode_out == `KPL_DISP_VALUE)
      else $error("open did not show value");
   zero_pattern_a:
      assert property ($rose(pw_sel_in) && nv_password_out == `KPL_PW_ZERO
         |-> ##[1:3] disp_value_out == `KPL_ENC_KEY)
      else $error("zero password pattern wrong");
   pass_needs_lock_a:
      assert property ($rose(disp_mode_out == `KPL_DISP_PASS) |-> nv_lock_en_out || nv_write_out)
      else $error("pass shown with lock off and no store");
   err_needs_lock_a:
      assert property ($rose(disp_mode_out == `KPL_DISP_ERR) |-> nv_lock_en_out)
      else $error("error shown with lock off");
endmodule // kpl_lock_sva
bind kpl_lock kpl_lock_sva u_sva (.core_clk_in, .resetn_in, .pw_sel_in, .edit_enter_in,
   .factory_restore_in, .disp_mode_out, .disp_value_out, .edit_grant_out, .nv_write_out,
   .nv_password_out, .nv_lock_en_out);

//--- dv/kpl_keypad_model.sv
// operator keypad model pressing one key at a time
`timescale 1ns/100ps
module kpl_keypad_model (
   input  wire  core_clk_in,
   output logic up_out,
   output logic down_out,
   output logic enter_out,
   output logic other_out
);
   logic [3:0] keys_q = 4'h0;
   assign {other_out, enter_out, down_out, up_out} = keys_q;
   // held four clocks, the two-flop synchroniser needs two
   task automatic press(input int k);
      @(posedge core_clk_in);
      keys_q <= 4'h1 << k;
      repeat (4) @(posedge core_clk_in);
      keys_q <= 4'h0;
      repeat (4) @(posedge core_clk_in);
   endtask
endmodule // kpl_keypad_model

//--- dv/kpl_lock_test.sv
// register and keypad tests of the parameter lock
`timescale 1ns/100ps
`include "kpl_regs.vh"
module kpl_lock_test;
   logic        clk = 1'b0, resetn = 1'b0, pw_sel = 1'b0, edit_ent = 1'b0, restore = 1'b0;
   logic        nv_lk = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [15:0] nv_pw = 16'h0000, disp, nv_pw_o;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, k_up, k_dn, k_ent, k_oth, grant, nv_wr, nv_lk_o;
   logic [1:0]  mode;
   int          n_mismatch = 0, tests_run = 0, n_grant = 0, n_wr = 0;
   kpl_keypad_model kp (.core_clk_in(clk), .up_out(k_up), .down_out(k_dn),
      .enter_out(k_ent), .other_out(k_oth));
   // short unlock window keeps the run brief
   kpl_lock #(.CW(8), .UNLOCK_CYC(64'd80)) dut (.core_clk_in(clk), .resetn_in(resetn),
      .key_up_in(k_up), .key_down_in(k_dn), .key_enter_in(k_ent), .key_other_in(k_oth),
      .pw_sel_in(pw_sel), .edit_enter_in(edit_ent), .factory_restore_in(restore),
      .nv_password_in(nv_pw), .nv_lock_en_in(nv_lk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .disp_value_out(disp), .disp_mode_out(mode),
      .edit_grant_out(grant), .nv_write_out(nv_wr), .nv_password_out(nv_pw_o),
      .nv_lock_en_out(nv_lk_o));
   initial forever #2.5 clk = ~clk;
   // pulses are counted here so no check races their single cycle
   always @(posedge clk) begin
      if (grant === 1'b1) n_grant++;
      if (nv_wr === 1'b1) n_wr++;
   end
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] %0t apb answer timed out", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic st(input logic [1:0] e);
      apb(1'b0, `KPL_STAT_OFF, 32'h0);
      chk(rd[1:0], e);
   endtask
   task automatic do_reset(input logic [15:0] p, input logic l);
      @(posedge clk);
      resetn <= 1'b0;
      nv_pw <= p;
      nv_lk <= l;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   task automatic pulse_edit;
      @(posedge clk);
      pw_sel <= 1'b0;
      edit_ent <= 1'b1;
      @(posedge clk);
      edit_ent <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic open_pw;
      @(posedge clk);
      pw_sel <= 1'b0;
      @(posedge clk);
      pw_sel <= 1'b1;
      repeat (3) @(posedge clk);
   endtask
   // first arrow shows zero, so v+1 presses reach v
   task automatic set_pw(input int v);
      open_pw;
      repeat (v + 1) kp.press(0);
      kp.press(2);
   endtask
   initial begin
      #50us;
      n_mismatch++;
      $display("[FAIL] %0t watchdog expired", $time);
      report_and_stop;
   end
   initial begin
      do_reset(16'h0000, 1'b0);
      st(2'h0);
      apb(1'b0, `KPL_CTRL_OFF, 32'h0);
      chk(rd, 32'h2);
      apb(1'b0, 12'h00c, 32'h0);
      chk(err, 1'b1);
      pulse_edit;
      chk(n_grant, 1);
      apb(1'b0, `KPL_ENC_OFF, 32'h0);
      chk(rd, 32'h3552);
      open_pw;
      chk({mode, disp}, {`KPL_DISP_VALUE, 16'h3552});
      $display("test power_up done");
      kp.press(0);
      chk(disp, 16'h0000);
      kp.press(0);
      chk(disp, 16'h0001);
      kp.press(2);
      chk({n_wr, nv_lk_o, nv_pw_o}, {32'd1, 1'b1, 16'h0001});
      st(2'h1);
      pulse_edit;
      chk({n_grant, mode}, {32'd1, `KPL_DISP_ERR});
      @(posedge clk);
      restore <= 1'b1;
      @(posedge clk);
      restore <= 1'b0;
      st(2'h1);
      chk(nv_pw_o, 16'h0001);
      set_pw(2);
      chk({n_wr, mode}, {32'd1, `KPL_DISP_ERR});
      st(2'h1);
      open_pw;
      chk(disp, 16'h3553);
      $display("test lock done");
      set_pw(1);
      chk(mode, `KPL_DISP_PASS);
      st(2'h3);
      repeat (50) @(posedge clk);
      kp.press(3);
      repeat (50) @(posedge clk);
      st(2'h3);
      repeat (100) @(posedge clk);
      st(2'h1);
      pulse_edit;
      chk({n_grant, mode}, {32'd1, `KPL_DISP_ERR});
      $display("test window done");
      set_pw(1);
      set_pw(2);
      chk({n_wr, nv_pw_o}, {32'd2, 16'h0002});
      st(2'h3);
      apb(1'b1, `KPL_CTRL_OFF, 32'h3);
      st(2'h1);
      set_pw(2);
      set_pw(0);
      chk({n_wr, nv_lk_o, nv_pw_o}, {32'd3, 1'b0, 16'h0000});
      pulse_edit;
      chk(n_grant, 2);
      $display("test change done");
      do_reset(16'h0002, 1'b1);
      st(2'h1);
      apb(1'b0, `KPL_ENC_OFF, 32'h0);
      chk(rd, 32'h3554);
      // down arrows wrap below zero
      open_pw;
      kp.press(1);
      kp.press(1);
      chk(disp, 16'h9999);
      // keys disabled from the bus must not move the entry
      apb(1'b1, `KPL_CTRL_OFF, 32'h0);
      kp.press(0);
      chk(disp, 16'h9999);
      apb(1'b1, `KPL_CTRL_OFF, 32'h2);
      kp.press(2);
      chk(mode, `KPL_DISP_ERR);
      $display("test storage done");
      report_and_stop;
   end
endmodule // kpl_lock_test
